// *** inc/oafd_params.svh ***
// Numeric constants of the operand address field decoder.
`ifndef OAFD_PARAMS_SVH
`define OAFD_PARAMS_SVH
`define OAFD_FORM_NODISP 2'h0
`define OAFD_FORM_DISP8 2'h1
`define OAFD_FORM_DISP32 2'h2
`define OAFD_FORM_REG 2'h3
`define OAFD_RM_SIB 3'h4
`define OAFD_RM_FP 3'h5
`define OAFD_REG_SP 3'h4
`define OAFD_REG_FP 3'h5
`define OAFD_NO_INDEX 3'h4
`define OAFD_SCALE_X1 2'h0
`define OAFD_FORM_HI 7
`define OAFD_FORM_LO 6
`define OAFD_REG_HI 5
`define OAFD_REG_LO 3
`define OAFD_RM_HI 2
`define OAFD_RM_LO 0
`define OAFD_SIB_SS_HI 7
`define OAFD_SIB_SS_LO 6
`define OAFD_SIB_IDX_HI 5
`define OAFD_SIB_IDX_LO 3
`define OAFD_SIB_BASE_HI 2
`define OAFD_SIB_BASE_LO 0
`define OAFD_DLEN_NONE 3'h0
`define OAFD_DLEN_ONE 3'h1
`define OAFD_DLEN_FOUR 3'h4
`define OAFD_CC_O 3'h0
`define OAFD_CC_B 3'h1
`define OAFD_CC_Z 3'h2
`define OAFD_CC_BE 3'h3
`define OAFD_CC_S 3'h4
`define OAFD_CC_P 3'h5
`define OAFD_CC_L 3'h6
`define OAFD_CC_LE 3'h7
`define OAFD_CC_TEST_HI 3
`define OAFD_CC_TEST_LO 1
`define OAFD_CC_FLIP_BIT 0
`define OAFD_BYTE_MSB 7
`define OAFD_SIGN_FILL 24
`define OAFD_BYTE_REG_SEL 2
`define OAFD_WIDTH_BYTE 2'h0
`define OAFD_WIDTH_16 2'h1
`define OAFD_WIDTH_32 2'h2
`define OAFD_SCALE_ONE 4'h1
`endif

// *** inc/oafd_pkg.sv ***
// Types shared by the operand address field decoder.
package oafd_pkg;
  typedef enum logic [1:0] {
    OAFD_SEG_DATA = 2'h1,
    OAFD_SEG_STACK = 2'h2
  } oafd_seg_t;

  typedef struct packed {
    logic [7:0] modrm;
    logic [7:0] sib;
    logic [31:0] disp;
    logic [31:0] imm;
    logic imm_is_8;
    logic dest_wide;
    logic op32;
    logic size_bit;
    logic target_pick_bit;
    logic extend_imm8;
    logic [3:0] cond_code;
  } oafd_in_t;

  typedef struct packed {
    logic [3:0] num;
    logic high_byte;
    logic [1:0] width;
  } oafd_reg_t;

  typedef struct packed {
    logic is_reg;
    logic sib_follows;
    logic [2:0] disp_len;
    logic base_valid;
    logic [2:0] base_reg;
    logic index_valid;
    logic [2:0] index_reg;
    logic [3:0] scale;
    logic [31:0] disp;
    logic ea_undefined;
    oafd_seg_t segment;
  } oafd_ea_t;

  typedef struct packed {
    logic of;
    logic cf;
    logic zf;
    logic sf;
    logic pf;
  } oafd_flags_t;
endpackage : oafd_pkg

// *** logic/oafd_cond_eval.sv ***
// Condition code evaluator for conditional jumps and set-on-condition.
`timescale 1ns/10ps
`include "oafd_params.svh"
module oafd_cond_eval
  import oafd_pkg::*;
(
  // Condition and flags.
  input wire logic [3:0] cond_code_i,
  input wire oafd_flags_t flags_i,
  // Result.
  output logic taken_o
);
  logic [2:0] sel;
  logic flip_flag;
  logic less;
  logic raw;

  assign sel = cond_code_i[`OAFD_CC_TEST_HI:`OAFD_CC_TEST_LO];
  assign flip_flag = cond_code_i[`OAFD_CC_FLIP_BIT];
  assign less = flags_i.sf ^ flags_i.of;

  always_comb begin
    case (sel)
      `OAFD_CC_O: raw = flags_i.of;
      `OAFD_CC_B: raw = flags_i.cf;
      `OAFD_CC_Z: raw = flags_i.zf;
      `OAFD_CC_BE: raw = flags_i.cf | flags_i.zf;
      `OAFD_CC_S: raw = flags_i.sf;
      `OAFD_CC_P: raw = flags_i.pf;
      `OAFD_CC_L: raw = less;
      `OAFD_CC_LE: raw = less | flags_i.zf;
      default: raw = 1'b0;
    endcase
  end

  assign taken_o = raw ^ flip_flag;
endmodule : oafd_cond_eval

// *** logic/oafd_decoder.sv ***
// Operand address field decoder, registered outputs.
// What this block does
// - Without scaled-index byte, rm picks base; form sets displacement; 100 means index byte.
// - 16-bit ops, form 11: low then high bytes, or 16-bit registers.
// - 32-bit ops: byte registers or 32-bit registers, 100 stack, 101 frame pointer.
// - With index byte: base plus scaled index plus displacement; base 101 form 00 is d32.
// - Index byte: stack pointer base, or frame pointer with displacement, uses stack segment.
// - Form from first byte; scale, index, base from index byte; scale 1,2,4,8.
// - Index code 100 adds no index; nonzero scale then gives undefined address.
// - Other index codes select 32-bit registers in standard order.
// - Direction bit 0: reg field source; 1: reg field destination.
// - Sign bit extends 8-bit immediate into wide destination; else unchanged.
// - Upper condition bits choose test; lowest bit negates it.
// - Codes 0000-0111: overflow, below, equal, below-or-equal, each with negation.
// - Codes 1000-1111: sign, parity, less, less-or-equal, each with negation.
`timescale 1ns/10ps
`include "oafd_params.svh"
module oafd_decoder
  import oafd_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Opcode fields and flags from the fetch path.
  input wire oafd_in_t op_i,
  input wire oafd_flags_t flags_i,
  // Decoded results.
  output oafd_ea_t ea_o,
  output oafd_reg_t reg_field_o,
  output oafd_reg_t rm_reg_o,
  output logic reg_is_dest_o,
  output logic rm_is_dest_o,
  output logic [31:0] imm_o,
  output logic cond_taken_o
);
  function automatic oafd_reg_t reg_sel(input logic [2:0] code, input logic size_bit, input logic op32);
    oafd_reg_t r;
    r.num = {1'b0, code};
    r.high_byte = 1'b0;
    r.width = `OAFD_WIDTH_BYTE;
    if (!size_bit) begin
      r.num = {2'h0, code[`OAFD_BYTE_REG_SEL-1:0]};
      r.high_byte = code[`OAFD_BYTE_REG_SEL];
    end else begin
      r.width = op32 ? `OAFD_WIDTH_32 : `OAFD_WIDTH_16;
    end
    return r;
  endfunction : reg_sel

  logic [1:0] form;
  logic [2:0] reg_code;
  logic [2:0] rm_code;
  logic [1:0] ss;
  logic [2:0] idx;
  logic [2:0] base;
  logic has_sib;
  logic mem_op;
  logic disp_only;
  logic [2:0] eff_base;
  logic [2:0] disp_len;
  logic [31:0] disp_ext;
  logic stack_seg;
  logic [31:0] imm_ext;
  logic taken;
  oafd_ea_t ea_d;
  oafd_ea_t ea_q;
  oafd_reg_t reg_field_q;
  oafd_reg_t rm_reg_q;
  logic reg_is_dest_q;
  logic [31:0] imm_q;
  logic taken_q;

  assign form = op_i.modrm[`OAFD_FORM_HI:`OAFD_FORM_LO];
  assign reg_code = op_i.modrm[`OAFD_REG_HI:`OAFD_REG_LO];
  assign rm_code = op_i.modrm[`OAFD_RM_HI:`OAFD_RM_LO];
  assign ss = op_i.sib[`OAFD_SIB_SS_HI:`OAFD_SIB_SS_LO];
  assign idx = op_i.sib[`OAFD_SIB_IDX_HI:`OAFD_SIB_IDX_LO];
  assign base = op_i.sib[`OAFD_SIB_BASE_HI:`OAFD_SIB_BASE_LO];

  assign mem_op = (form != `OAFD_FORM_REG);
  assign has_sib = mem_op && (rm_code == `OAFD_RM_SIB);
  assign eff_base = has_sib ? base : rm_code;
  assign disp_only = (form == `OAFD_FORM_NODISP) && (eff_base == `OAFD_RM_FP);

  // Displacement length and sign-extended short displacement.
  assign disp_len = (form == `OAFD_FORM_DISP8) ? `OAFD_DLEN_ONE :
                    ((form == `OAFD_FORM_DISP32) || (mem_op && disp_only)) ? `OAFD_DLEN_FOUR :
                    `OAFD_DLEN_NONE;
  assign disp_ext = (form == `OAFD_FORM_DISP8) ?
                    {{`OAFD_SIGN_FILL{op_i.disp[`OAFD_BYTE_MSB]}}, op_i.disp[`OAFD_BYTE_MSB:0]} :
                    (disp_len == `OAFD_DLEN_FOUR) ? op_i.disp : 32'h0;

  // Stack segment selection.
  assign stack_seg = has_sib ?
    ((base == `OAFD_REG_SP) || ((base == `OAFD_REG_FP) && (form != `OAFD_FORM_NODISP))) :
    ((rm_code == `OAFD_RM_FP) && (form != `OAFD_FORM_NODISP));

  always_comb begin
    ea_d.is_reg = !mem_op;
    ea_d.sib_follows = has_sib;
    ea_d.disp_len = mem_op ? disp_len : `OAFD_DLEN_NONE;
    ea_d.base_valid = mem_op && !disp_only;
    ea_d.base_reg = eff_base;
    ea_d.index_valid = has_sib && (idx != `OAFD_NO_INDEX);
    ea_d.index_reg = idx;
    ea_d.scale = `OAFD_SCALE_ONE << ss;
    ea_d.disp = mem_op ? disp_ext : 32'h0;
    ea_d.ea_undefined = has_sib && (idx == `OAFD_NO_INDEX) && (ss != `OAFD_SCALE_X1);
    ea_d.segment = stack_seg ? OAFD_SEG_STACK : OAFD_SEG_DATA;
  end

  // Immediate sign extension.
  assign imm_ext = (op_i.extend_imm8 && op_i.imm_is_8 && op_i.dest_wide) ?
                   {{`OAFD_SIGN_FILL{op_i.imm[`OAFD_BYTE_MSB]}}, op_i.imm[`OAFD_BYTE_MSB:0]} : op_i.imm;

  oafd_cond_eval u_cond (
    .cond_code_i(op_i.cond_code),
    .flags_i(flags_i),
    .taken_o(taken)
  );

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ea_q <= '0;
      reg_field_q <= '0;
      rm_reg_q <= '0;
      reg_is_dest_q <= 1'b0;
      imm_q <= 32'h0;
      taken_q <= 1'b0;
    end else begin
      ea_q <= ea_d;
      reg_field_q <= reg_sel(reg_code, op_i.size_bit, op_i.op32);
      rm_reg_q <= reg_sel(rm_code, op_i.size_bit, op_i.op32);
      reg_is_dest_q <= op_i.target_pick_bit;
      imm_q <= imm_ext;
      taken_q <= taken;
    end
  end

  assign ea_o = ea_q;
  assign reg_field_o = reg_field_q;
  assign rm_reg_o = rm_reg_q;
  assign reg_is_dest_o = reg_is_dest_q;
  assign rm_is_dest_o = !reg_is_dest_q;
  assign imm_o = imm_q;
  assign cond_taken_o = taken_q;
endmodule : oafd_decoder

// *** verification/oafd_checker.sv ***
// Port checker of the operand address field decoder.
`timescale 1ns/10ps
module oafd_checker
  import oafd_pkg::*;
(
  // Inputs.
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire oafd_in_t op_i,
  input wire oafd_flags_t flags_i,
  // Outputs.
  input wire oafd_ea_t ea_o,
  input wire oafd_reg_t reg_field_o,
  input wire oafd_reg_t rm_reg_o,
  input wire logic reg_is_dest_o,
  input wire logic rm_is_dest_o,
  input wire logic [31:0] imm_o,
  input wire logic cond_taken_o
);
  logic v_q;
  oafd_in_t p_q;
  oafd_flags_t f_q;
  wire [1:0] md = p_q.modrm[7:6];
  wire [2:0] rm = p_q.modrm[2:0];
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) v_q <= 1'b0;
    else v_q <= 1'b1;
  end
  always_ff @(posedge clk_i) begin
    p_q <= op_i;
    f_q <= flags_i;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sib_flag_a: assert property (v_q |-> ea_o.sib_follows == (md != 2'h3 && rm == 3'h4))
    else $error("sib flag wrong");
  disp_one_a: assert property (v_q && md == 2'h1 |-> ea_o.disp_len == 3'h1)
    else $error("disp length wrong");
  fp_stack_a: assert property (v_q && md != 2'h0 && md != 2'h3 && rm == 3'h5
    |-> ea_o.segment == OAFD_SEG_STACK)
    else $error("segment wrong");
  scale_val_a: assert property (v_q && ea_o.sib_follows |-> ea_o.scale == 4'h1 << p_q.sib[7:6])
    else $error("scale wrong");
  undef_ea_a: assert property (v_q && ea_o.sib_follows
    |-> ea_o.ea_undefined == (p_q.sib[5:3] == 3'h4 && p_q.sib[7:6] != 2'h0))
    else $error("undefined flag wrong");
  dir_bit_a: assert property (v_q
    |-> reg_is_dest_o == p_q.target_pick_bit && rm_is_dest_o != p_q.target_pick_bit)
    else $error("direction wrong");
  imm_ext_a: assert property (v_q && p_q.extend_imm8 && p_q.imm_is_8 && p_q.dest_wide
    |-> imm_o[31:8] == {24{p_q.imm[7]}})
    else $error("immediate wrong");
  less_not_a: assert property (v_q && p_q.cond_code == 4'hd |-> cond_taken_o == (f_q.sf ~^ f_q.of))
    else $error("condition wrong");
endmodule : oafd_checker
bind oafd_decoder oafd_checker chk_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .op_i(op_i), .flags_i(flags_i),
  .ea_o(ea_o), .reg_field_o(reg_field_o), .rm_reg_o(rm_reg_o), .reg_is_dest_o(reg_is_dest_o),
  .rm_is_dest_o(rm_is_dest_o), .imm_o(imm_o), .cond_taken_o(cond_taken_o));

// *** verification/oafd_fetch_model.sv ***
// Prefetch side model that hands opcode fields to the decoder.
`timescale 1ns/10ps
module oafd_fetch_model
  import oafd_pkg::*;
(
  // Clock.
  input wire logic clk_i,
  // Opcode fields.
  output oafd_in_t op_o
);
  initial op_o = '0;
  // A good producer clears the scale when no index is used.
  task automatic send(input oafd_in_t x, input logic bad);
    if (!bad && x.sib[5:3] == 3'h4) x.sib[7:6] = 2'h0;
    op_o <= x;
  endtask : send
endmodule : oafd_fetch_model

// *** verification/operand_address_field_decoder_tb_top.sv ***
// Self-checking bench of the operand address field decoder.
`timescale 1ns/10ps
module operand_address_field_decoder_tb_top
  import oafd_pkg::*;
;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  oafd_in_t op;
  oafd_flags_t flags_i = '0;
  oafd_ea_t ea;
  oafd_reg_t rf;
  oafd_reg_t rr;
  logic rd;
  logic md;
  logic [31:0] imm;
  logic ct;
  int bad_count = 0;
  int comparisons = 0;
  always #5 clk_i = ~clk_i;
  oafd_fetch_model pf_u (.clk_i(clk_i), .op_o(op));
  oafd_decoder dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .op_i(op), .flags_i(flags_i), .ea_o(ea),
    .reg_field_o(rf), .rm_reg_o(rr), .reg_is_dest_o(rd), .rm_is_dest_o(md), .imm_o(imm), .cond_taken_o(ct));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk
  function automatic logic [6:0] exp_reg(input logic [2:0] c, input logic wide, input logic op32);
    return wide ? {1'b0, c, 1'b0, op32 ? 2'h2 : 2'h1} : {2'h0, c[1:0], c[2], 2'h0};
  endfunction : exp_reg
  task automatic run(input oafd_in_t x, input logic bad, input oafd_flags_t f);
    @(posedge clk_i);
    flags_i <= f;
    pf_u.send(x, bad);
    @(posedge clk_i);
    #1;
  endtask : run
  task automatic t_modrm();
    oafd_in_t x;
    logic [31:0] dx;
    x = '0;
    x.disp = 32'h1234_5680;
    for (int i = 0; i < 24; i++) begin
      x.modrm = {i[4:3], 3'h0, i[2:0]};
      run(x, 1'b0, '0);
      chk("sib", i[2:0] == 4, ea.sib_follows);
      chk("mem", 0, ea.is_reg);
      if (i[2:0] != 4) begin
        chk("dlen", i[4:3] == 1 ? 1 : (i[4:3] == 2 || i[2:0] == 5) ? 4 : 0, ea.disp_len);
        chk("bv", i[4:3] != 0 || i[2:0] != 5, ea.base_valid);
        chk("base", i[2:0], ea.base_reg);
        dx = i[4:3] == 1 ? 32'hffff_ff80 : (i[4:3] == 2 || i[2:0] == 5) ? 32'h1234_5680 : 32'h0;
        chk("disp", dx, ea.disp);
        chk("seg", (i[4:3] != 0 && i[2:0] == 5) ? 2 : 1, ea.segment);
      end
    end
    $display("modrm test done");
  endtask : t_modrm
  task automatic t_sib();
    oafd_in_t x;
    logic [2:0] ix;
    logic [31:0] dx;
    x = '0;
    x.disp = 32'h1234_5680;
    for (int i = 0; i < 24; i++) begin
      ix = i[2:0] ^ 3'h2;
      x.modrm = {i[4:3], 6'h04};
      x.sib = {i[1:0], ix, i[2:0]};
      run(x, 1'b0, '0);
      dx = i[4:3] == 1 ? 32'hffff_ff80 : (i[4:3] == 2 || i[2:0] == 5) ? 32'h1234_5680 : 32'h0;
      chk("disp", dx, ea.disp);
      chk("base", i[2:0], ea.base_reg);
      chk("dlen", i[4:3] == 1 ? 1 : (i[4:3] == 2 || i[2:0] == 5) ? 4 : 0, ea.disp_len);
      chk("scale", ix == 4 ? 1 : 1 << i[1:0], ea.scale);
      chk("idx", {ix != 4, ix}, {ea.index_valid, ea.index_valid ? ea.index_reg : ix});
      chk("bv", i[4:3] != 0 || i[2:0] != 5, ea.base_valid);
      chk("seg", (i[2:0] == 4 || (i[2:0] == 5 && i[4:3] != 0)) ? 2 : 1, ea.segment);
    end
    x.sib = 8'he4;
    run(x, 1'b1, '0);
    chk("undef", 1, ea.ea_undefined);
    $display("sib test done");
  endtask : t_sib
  task automatic t_regs();
    oafd_in_t x;
    x = '0;
    for (int i = 0; i < 32; i++) begin
      x.modrm = {2'h3, i[2:0] ^ 3'h5, i[2:0]};
      x.op32 = i[4];
      x.size_bit = i[3];
      x.target_pick_bit = i[0];
      run(x, 1'b0, '0);
      chk("rm", exp_reg(i[2:0], i[3], i[4]), rr);
      chk("reg", exp_reg(i[2:0] ^ 3'h5, i[3], i[4]), rf);
      chk("isreg", 1, ea.is_reg);
      chk("rdlen", 0, ea.disp_len);
      chk("dir", {i[0], !i[0]}, {rd, md});
    end
    $display("register test done");
  endtask : t_regs
  task automatic t_imm_cond();
    oafd_in_t x;
    logic t;
    oafd_flags_t f;
    x = '0;
    for (int i = 0; i < 512; i++) begin
      f = i[8:4];
      x.cond_code = i[3:0];
      x.imm = {24'h0, i[7:0]};
      {x.extend_imm8, x.imm_is_8, x.dest_wide} = i[2:0];
      run(x, 1'b0, f);
      chk("imm", i[2:0] == 7 ? {{24{i[7]}}, i[7:0]} : {24'h0, i[7:0]}, imm);
      case (i[3:1])
        0: t = f.of;
        1: t = f.cf;
        2: t = f.zf;
        3: t = f.cf | f.zf;
        4: t = f.sf;
        5: t = f.pf;
        6: t = f.sf ^ f.of;
        default: t = (f.sf ^ f.of) | f.zf;
      endcase
      chk("cond", t ^ i[0], ct);
    end
    $display("immediate and condition test done");
  endtask : t_imm_cond
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report
  initial begin
    repeat (5000) @(posedge clk_i);
    bad_count++;
    final_report();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_modrm();
    t_sib();
    t_regs();
    t_imm_cond();
    final_report();
  end
endmodule : operand_address_field_decoder_tb_top
